// File: include/timer_flags_pkg.sv
// Constants, register layout and state codes of the timer status flag block.
// Assumes one clock domain and a single-word register port per access.
// Functional notes
// - Enable bit 3 gates flag D onto its request
// - Enable bit 2 gates flag C; channel 0 only
// - Enable bit 1 gates flag B onto its request
// - Enable bit 0 gates flag A onto its request
// - One 8-bit status register per channel, three
// - Status resets to C0 on reset and standby
// - Software writes only zeros, never sets a flag
// - Zero write clears only a flag read as one
// - Bit 7 shows count direction; channel 0 reads one
// - Status bit 6 reads one, write it one
// - Bit 5 sets on underflow, channels 1 and 2
// - Channel 0 status bit 5 reads zero
// - Bit 4 sets on overflow, every channel
// - Bit 3 sets on D match or capture
// - Bit 2 sets on C match, channel 0 only
// - Bit 1 sets on B match or capture
// - Bit 0 sets on A match or capture
// - Finished DMA transfer from flag A clears it
// - Enable bit 4 gates overflow flag onto request
// - Enable bit 5 gates underflow, channels 1 and 2
package timer_flags_pkg;
  localparam int CHANNELS = 3;
  localparam int FLAG_W = 6;
  localparam int SEL_W = 3;
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_C = 2;
  localparam int FLAG_D = 3;
  localparam int FLAG_OVF = 4;
  localparam int FLAG_UDF = 5;
  localparam int DIR_BIT = 7;
  localparam int ADC_EN_BIT = 7;
  // Device register select: enables first, then status words.
  localparam logic [SEL_W-1:0] SEL_EN_BASE = 3'h0;
  localparam logic [SEL_W-1:0] SEL_ST_BASE = 3'h3;
  localparam logic [SEL_W-1:0] SEL_COUNT = 3'h6;
  localparam logic [7:0] STAT_RESET = 8'hc0;
  localparam logic [7:0] STAT_FIXED = 8'h40;
  localparam logic [7:0] EN_RESET = 8'h40;
  localparam logic [7:0] EN_MASK_CH0 = 8'h9f;
  localparam logic [7:0] EN_MASK_CH12 = 8'hb3;
  localparam logic [FLAG_W-1:0] FLAG_MASK_CH0 = 6'h1f;
  localparam logic [FLAG_W-1:0] FLAG_MASK_CH12 = 6'h33;
  // Software side: word index times four gives the byte address.
  localparam int ADDR_LSB = 2;
  localparam int MIN_ADDR_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DEV = 4'b0010,
    ST_BRESP = 4'b0100,
    ST_RRESP = 4'b1000
  } ctrl_state_t;

  function automatic logic [FLAG_W-1:0] flag_mask(input int ch);
    return (ch == 0) ? FLAG_MASK_CH0 : FLAG_MASK_CH12;
  endfunction

  function automatic logic [7:0] en_mask(input int ch);
    return (ch == 0) ? EN_MASK_CH0 : EN_MASK_CH12;
  endfunction
endpackage

// File: include/timer_flags_if.sv
// Register port between the status flag block and its controller.
// Assumes both ends run on the same clock; one request at a time.
`timescale 1ns/1ps
interface timer_flags_if;
  logic req;
  logic we;
  logic [timer_flags_pkg::SEL_W-1:0] sel;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (
    input req,
    input we,
    input sel,
    input wdata,
    output ack,
    output rdata
  );

  modport ctrl (
    output req,
    output we,
    output sel,
    output wdata,
    input ack,
    input rdata
  );
endinterface

// File: design/timer_flags_dev.sv
// Status flags, interrupt enables and request lines of a three channel timer.
// Assumes counter events arrive as one-cycle pulses on aclk and that the
// controller issues one register request at a time on the port.
`timescale 1ns/1ps
module timer_flags_dev (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  timer_flags_if.dev rp,
  input wire logic [timer_flags_pkg::CHANNELS-1:0] cmp_a_event,
  input wire logic [timer_flags_pkg::CHANNELS-1:0] cmp_b_event,
  input wire logic cmp_c_event,
  input wire logic cmp_d_event,
  input wire logic [timer_flags_pkg::CHANNELS-1:0] ovf_event,
  input wire logic [timer_flags_pkg::CHANNELS-1:0] udf_event,
  input wire logic [timer_flags_pkg::CHANNELS-1:0] count_up,
  input wire logic [timer_flags_pkg::CHANNELS-1:0] dma_done_a,
  output logic [timer_flags_pkg::CHANNELS-1:0] cmp_a_irq,
  output logic [timer_flags_pkg::CHANNELS-1:0] cmp_b_irq,
  output logic cmp_c_irq,
  output logic cmp_d_irq,
  output logic [timer_flags_pkg::CHANNELS-1:0] overflow_irq,
  output logic [timer_flags_pkg::CHANNELS-1:0] underflow_irq,
  output logic [timer_flags_pkg::CHANNELS-1:0] adc_start_req
);

  localparam int NCH = timer_flags_pkg::CHANNELS;
  localparam int FW = timer_flags_pkg::FLAG_W;

  logic ack_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] st_word [NCH];
  logic [7:0] en_word [NCH];
  logic [FW-1:0] irq_word [NCH];
  logic [NCH-1:0] adc_word;
  logic clear_all;

  // Standby returns the block to its reset state, like a power-on reset.
  assign clear_all = !aresetn || standby;

  ////////////////////////////////////////////////////////////////////////////
  // Per channel flags, enables and requests.
  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      localparam logic [FW-1:0] FMASK = timer_flags_pkg::flag_mask(c);
      localparam logic [7:0] EMASK = timer_flags_pkg::en_mask(c);
      localparam logic [2:0] EN_SEL =
        3'(timer_flags_pkg::SEL_EN_BASE + 3'(c));
      localparam logic [2:0] ST_SEL =
        3'(timer_flags_pkg::SEL_ST_BASE + 3'(c));

      logic [FW-1:0] flags_reg;
      logic [FW-1:0] flags_next;
      logic [FW-1:0] armed_reg;
      logic [FW-1:0] armed_next;
      logic [7:0] en_reg;
      logic [7:0] en_next;
      logic [FW-1:0] irq_reg;
      logic adc_reg;
      logic dir_reg;
      logic [FW-1:0] set_vec;
      logic [FW-1:0] clr_vec;
      logic st_hit;
      logic en_hit;

      assign st_hit = rp.req && (rp.sel == ST_SEL);
      assign en_hit = rp.req && (rp.sel == EN_SEL);

      always_comb
      begin
        set_vec = '0;
        set_vec[timer_flags_pkg::FLAG_A] = cmp_a_event[c];
        set_vec[timer_flags_pkg::FLAG_B] = cmp_b_event[c];
        set_vec[timer_flags_pkg::FLAG_OVF] = ovf_event[c];
        set_vec[timer_flags_pkg::FLAG_UDF] = udf_event[c];
        if (c == 0)
        begin
          set_vec[timer_flags_pkg::FLAG_C] = cmp_c_event;
          set_vec[timer_flags_pkg::FLAG_D] = cmp_d_event;
        end
        // Only flags absent on this channel are masked away.
        set_vec = set_vec & FMASK;
        clr_vec = '0;
        // A zero clears only an armed flag; ones are ignored.
        if (st_hit && rp.we)
        begin
          clr_vec = ~rp.wdata[FW-1:0] & armed_reg;
        end
        clr_vec[timer_flags_pkg::FLAG_A] = clr_vec[timer_flags_pkg::FLAG_A]
          | dma_done_a[c];
        // Set is applied after the clear, so it wins.
        flags_next = ((flags_reg & ~clr_vec) | set_vec) & FMASK;
        // A read arms every flag it returned as one.
        if (st_hit && !rp.we)
        begin
          armed_next = armed_reg | flags_reg;
        end
        else
        begin
          armed_next = armed_reg & ~clr_vec;
        end
        armed_next = armed_next & flags_next;
        en_next = en_reg;
        if (en_hit && rp.we)
        begin
          en_next = (rp.wdata & EMASK)
            | timer_flags_pkg::EN_RESET;
        end
      end

      always_ff @(posedge aclk)
      begin
        if (clear_all)
        begin
          flags_reg <= '0;
          armed_reg <= '0;
        end
        else
        begin
          flags_reg <= flags_next;
          armed_reg <= armed_next;
        end
      end

      always_ff @(posedge aclk)
      begin
        if (clear_all)
        begin
          en_reg <= timer_flags_pkg::EN_RESET;
        end
        else
        begin
          en_reg <= en_next;
        end
      end

      // Direction is up after reset; channels 1 and 2 then follow the counter, channel 0 stays up.
      always_ff @(posedge aclk)
      begin
        if (clear_all)
        begin
          dir_reg <= timer_flags_pkg::STAT_RESET[timer_flags_pkg::DIR_BIT];
        end
        else
        begin
          dir_reg <= (c == 0) ? 1'b1 : count_up[c];
        end
      end

      // Interrupt requests follow the flags in the same cycle as the stored value; ADC start pulses on each enabled flag A set.
      always_ff @(posedge aclk)
      begin
        if (clear_all)
        begin
          irq_reg <= '0;
          adc_reg <= 1'b0;
        end
        else
        begin
          irq_reg <= flags_next & en_next[FW-1:0];
          adc_reg <= set_vec[timer_flags_pkg::FLAG_A]
            & en_reg[timer_flags_pkg::ADC_EN_BIT];
        end
      end

      assign st_word[c] = {dir_reg, timer_flags_pkg::STAT_FIXED[6],
        flags_reg};
      assign en_word[c] = en_reg;
      assign irq_word[c] = irq_reg;
      assign adc_word[c] = adc_reg;
      assign cmp_a_irq[c] = irq_reg[timer_flags_pkg::FLAG_A];
      assign cmp_b_irq[c] = irq_reg[timer_flags_pkg::FLAG_B];
      assign overflow_irq[c] =
        irq_reg[timer_flags_pkg::FLAG_OVF];
      assign underflow_irq[c] =
        irq_reg[timer_flags_pkg::FLAG_UDF];
    end
  endgenerate

  assign cmp_c_irq = irq_word[0][timer_flags_pkg::FLAG_C];
  assign cmp_d_irq = irq_word[0][timer_flags_pkg::FLAG_D];
  assign adc_start_req = adc_word;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux and answer.
  always_comb
  begin
    rdata_next = '0;
    for (int i = 0; i < NCH; i++)
    begin
      if (rp.sel == 3'(timer_flags_pkg::SEL_EN_BASE + 3'(i)))
      begin
        rdata_next = en_word[i];
      end
      if (rp.sel == 3'(timer_flags_pkg::SEL_ST_BASE + 3'(i)))
      begin
        rdata_next = st_word[i];
      end
    end
  end

  // Every request is answered one cycle later; unknown selects read zero.
  always_ff @(posedge aclk)
  begin
    if (clear_all)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= rp.req;
      if (rp.req && !rp.we)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign rp.ack = ack_reg;
  assign rp.rdata = rdata_reg;

endmodule // timer_flags_dev

// File: design/timer_flags_ctrl.sv
// AXI4-Lite slave that forwards software accesses to the flag block.
// Assumes one clock; word n of the map is device register select n.
`timescale 1ns/1ps
module timer_flags_ctrl #(
  parameter int ADDR_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  timer_flags_if.ctrl rp,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  generate
    if (ADDR_W < timer_flags_pkg::MIN_ADDR_W)
    begin : g_bad_addr_w
      $error("ADDR_W too small for the register map.");
    end
  endgenerate

  timer_flags_pkg::ctrl_state_t state_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic ar_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [ADDR_W-1:0] ar_addr_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic op_write_reg;
  logic awready_reg;
  logic wready_reg;
  logic arready_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic req_reg;
  logic we_reg;
  logic [2:0] sel_reg;
  logic [7:0] wdata_reg;
  logic idle;

  function automatic logic map_ok(input logic [ADDR_W-1:0] a);
    return (a[timer_flags_pkg::ADDR_LSB-1:0] == '0)
      && ((a >> timer_flags_pkg::ADDR_LSB)
        < ADDR_W'(timer_flags_pkg::SEL_COUNT));
  endfunction

  function automatic logic [2:0] sel_of(input logic [ADDR_W-1:0] a);
    return a[timer_flags_pkg::ADDR_LSB +: 3];
  endfunction

  assign idle = (state_reg == timer_flags_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Address and data capture, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      ar_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      aw_addr_reg <= '0;
      ar_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= 1'b0;
    end
    else
    begin
      awready_reg <= idle && !aw_full_reg && !(s_axi_awvalid && awready_reg);
      wready_reg <= idle && !w_full_reg && !(s_axi_wvalid && wready_reg);
      arready_reg <= idle && !ar_full_reg && !(s_axi_arvalid && arready_reg);
      if (s_axi_awvalid && awready_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (s_axi_arvalid && arready_reg)
      begin
        ar_full_reg <= 1'b1;
        ar_addr_reg <= s_axi_araddr;
      end
      if (idle && aw_full_reg && w_full_reg)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
      else if (idle && ar_full_reg)
      begin
        ar_full_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: writes before reads, one device access at a time.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= timer_flags_pkg::ST_IDLE;
      op_write_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      sel_reg <= '0;
      wdata_reg <= '0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= timer_flags_pkg::RESP_OKAY;
      rresp_reg <= timer_flags_pkg::RESP_OKAY;
      rdata_reg <= timer_flags_pkg::RDATA_NONE;
    end
    else
    begin
      req_reg <= 1'b0;
      case (state_reg)
        timer_flags_pkg::ST_IDLE:
        begin
          if (aw_full_reg && w_full_reg)
          begin
            op_write_reg <= 1'b1;
            sel_reg <= sel_of(aw_addr_reg);
            wdata_reg <= w_data_reg;
            we_reg <= 1'b1;
            if (map_ok(aw_addr_reg) && w_strb_reg)
            begin
              req_reg <= 1'b1;
              state_reg <= timer_flags_pkg::ST_DEV;
            end
            else
            begin
              bvalid_reg <= 1'b1;
              bresp_reg <= map_ok(aw_addr_reg) ? timer_flags_pkg::RESP_OKAY
                : timer_flags_pkg::RESP_SLVERR;
              state_reg <= timer_flags_pkg::ST_BRESP;
            end
          end
          else if (ar_full_reg)
          begin
            op_write_reg <= 1'b0;
            sel_reg <= sel_of(ar_addr_reg);
            we_reg <= 1'b0;
            if (map_ok(ar_addr_reg))
            begin
              req_reg <= 1'b1;
              state_reg <= timer_flags_pkg::ST_DEV;
            end
            else
            begin
              rvalid_reg <= 1'b1;
              rresp_reg <= timer_flags_pkg::RESP_SLVERR;
              rdata_reg <= timer_flags_pkg::RDATA_NONE;
              state_reg <= timer_flags_pkg::ST_RRESP;
            end
          end
        end
        timer_flags_pkg::ST_DEV:
        begin
          if (rp.ack && op_write_reg)
          begin
            bvalid_reg <= 1'b1;
            bresp_reg <= timer_flags_pkg::RESP_OKAY;
            state_reg <= timer_flags_pkg::ST_BRESP;
          end
          else if (rp.ack)
          begin
            rvalid_reg <= 1'b1;
            rresp_reg <= timer_flags_pkg::RESP_OKAY;
            rdata_reg <= {24'h00_0000, rp.rdata};
            state_reg <= timer_flags_pkg::ST_RRESP;
          end
        end
        timer_flags_pkg::ST_BRESP:
        begin
          if (s_axi_bready)
          begin
            bvalid_reg <= 1'b0;
            state_reg <= timer_flags_pkg::ST_IDLE;
          end
        end
        timer_flags_pkg::ST_RRESP:
        begin
          if (s_axi_rready)
          begin
            rvalid_reg <= 1'b0;
            state_reg <= timer_flags_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= timer_flags_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign rp.req = req_reg;
  assign rp.we = we_reg;
  assign rp.sel = sel_reg;
  assign rp.wdata = wdata_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule // timer_flags_ctrl

// File: tb/timer_flags_asserts.sv
// Concurrent checks on the register port and request lines of the flags.
// Assumes one clock; the bench instantiates it beside the interface.
`timescale 1ns/1ps
module timer_flags_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  input wire logic req,
  input wire logic we,
  input wire logic [2:0] sel,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic [2:0] cmp_a_event,
  input wire logic [2:0] ovf_event,
  input wire logic [2:0] cmp_a_irq,
  input wire logic [2:0] cmp_b_irq,
  input wire logic cmp_c_irq,
  input wire logic cmp_d_irq,
  input wire logic [2:0] overflow_irq,
  input wire logic [2:0] underflow_irq
);
  // Shadow of the enable registers, as written over the port.
  logic [7:0] en_reg [3];
  logic en_wr;
  assign en_wr = req && we && (sel < 3'h3);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || standby)
      en_reg <= '{default: 8'h40};
    else if (en_wr)
      en_reg[sel[1:0]] <= wdata;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || standby);

  ack_follows_req_a: assert property (req |=> ack)
    else $error("ack missing after request");
  ack_has_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  // Standby clears the read data, so the edge after it is not compared.
  rdata_held_a: assert property (
    !(ack && !we) && $past(aresetn) && !$past(standby) |-> $stable(rdata))
    else $error("read data changed outside a read");
  a_irq_set_a: assert property (
    cmp_a_event[0] && en_reg[0][0] && !en_wr |=> cmp_a_irq[0])
    else $error("flag A request missing");
  d_irq_gate_a: assert property (!en_reg[0][3] |-> !cmp_d_irq)
    else $error("flag D request while disabled");
  c_irq_gate_a: assert property (!en_reg[0][2] |-> !cmp_c_irq)
    else $error("flag C request while disabled");
  ovf_irq_set_a: assert property (
    ovf_event[2] && en_reg[2][4] && !en_wr |=> overflow_irq[2])
    else $error("overflow request missing");
  udf_zero_a: assert property (!underflow_irq[0])
    else $error("underflow request on channel 0");
  b_irq_hold_a: assert property (
    cmp_b_irq[1] && !(req && we) |=> cmp_b_irq[1])
    else $error("flag B request dropped");

  cover property (req && we && sel >= 3'h3);
  cover property (cmp_d_irq && cmp_c_irq);
  cover property (ack && !we);
endmodule // timer_flags_asserts

// File: tb/timer_status_irq_flags_tb.sv
// Bench joining the AXI4-Lite controller and the flag block by interface.
// Assumes package and interface compile first; drives both user sides.
`timescale 1ns/1ps
module timer_status_irq_flags_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0, standby = 1'b0;
  logic [2:0] ev_a = 3'h0, ev_b = 3'h0, ev_o = 3'h0, ev_u = 3'h0;
  logic ev_c = 1'b0, ev_d = 1'b0;
  logic [2:0] cnt_up = 3'h7, dma = 3'h0;
  logic [2:0] ia, ib, io, iu;
  logic ic, id;
  logic [2:0] adc;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, got_resp;
  logic [31:0] rdat, got;
  int n_mismatch = 0, n_tests = 0;
  // Rows: address, write byte, expected read byte, expected response.
  logic [31:0] rows [6] = '{32'h00ff_df00, 32'h04ff_f300, 32'h0810_5000,
    32'h0cdf_c000, 32'h14c0_c000, 32'h18ff_0002};

  timer_flags_if fl ();
  timer_flags_dev i_timer_flags_dev (.aclk(aclk), .aresetn(aresetn),
    .standby(standby), .rp(fl), .cmp_a_event(ev_a), .cmp_b_event(ev_b),
    .cmp_c_event(ev_c), .cmp_d_event(ev_d), .ovf_event(ev_o),
    .udf_event(ev_u), .count_up(cnt_up), .dma_done_a(dma),
    .cmp_a_irq(ia), .cmp_b_irq(ib), .cmp_c_irq(ic), .cmp_d_irq(id),
    .overflow_irq(io), .underflow_irq(iu), .adc_start_req(adc));
  timer_flags_ctrl #(.ADDR_W(5)) i_timer_flags_ctrl (.aclk(aclk),
    .aresetn(aresetn), .rp(fl), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdat),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  timer_flags_asserts i_timer_flags_asserts (.aclk(aclk),
    .aresetn(aresetn), .standby(standby), .req(fl.req), .we(fl.we),
    .sel(fl.sel), .wdata(fl.wdata), .ack(fl.ack), .rdata(fl.rdata),
    .cmp_a_event(ev_a), .ovf_event(ev_o), .cmp_a_irq(ia),
    .cmp_b_irq(ib), .cmp_c_irq(ic), .cmp_d_irq(id), .overflow_irq(io),
    .underflow_irq(iu));

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdat <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && k < 40);
    got_resp = bresp;
    bready <= 1'b0;
    if (!bvalid)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [4:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && k < 40);
    got = rdat;
    got_resp = rresp;
    rready <= 1'b0;
    if (!rvalid)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(5'(4 * i));
      check(got, (i < 3) ? 32'h0000_0040 : 32'h0000_00c0);
    end
    foreach (rows[i])
    begin
      wr(rows[i][28:24], rows[i][23:16]);
      check(32'(got_resp), 32'(rows[i][1:0]));
      rd(rows[i][28:24]);
      check(got, 32'(rows[i][15:8]));
      check(32'(got_resp), 32'(rows[i][1:0]));
    end
    {ev_a, ev_b, ev_c, ev_d, ev_o, ev_u} <= 14'h3fff;
    @(posedge aclk);
    {ev_a, ev_b, ev_c, ev_d, ev_o, ev_u} <= 14'h0000;
    @(posedge aclk);
    check(32'(ia), 32'h0000_0003);
    check(32'(ib), 32'h0000_0003);
    check(32'(io), 32'h0000_0007);
    check(32'(iu), 32'h0000_0002);
    check(32'({ic, id}), 32'h0000_0003);
    check(32'(adc), 32'h0000_0003);
    rd(5'h0c);
    check(got, 32'h0000_00df);
    rd(5'h10);
    check(got, 32'h0000_00f3);
    wr(5'h14, 8'hc0);
    rd(5'h14);
    check(got, 32'h0000_00f3);
    wr(5'h14, 8'hc0);
    rd(5'h14);
    check(got, 32'h0000_00c0);
    wr(5'h0c, 8'hc2);
    rd(5'h0c);
    check(got, 32'h0000_00c2);
    check(32'({ia[0], ib[0], ic, id}), 32'h0000_0004);
    // The overflow pulse is sampled at the same edge as the clearing write.
    fork
      wr(5'h10, 8'h40);
      begin
        for (int k = 0; k < 40 && fl.req !== 1'b1; k++)
          @(fl.req or posedge aclk);
        if (fl.req !== 1'b1)
        begin
          n_mismatch++;
          end_sim();
        end
        ev_o <= 3'h2;
        @(posedge aclk);
        ev_o <= 3'h0;
      end
    join
    wr(5'h10, 8'h40);
    rd(5'h10);
    check(got, 32'h0000_00d0);
    check(32'(io), 32'h0000_0002);
    ev_a <= 3'h1;
    @(posedge aclk);
    ev_a <= 3'h0;
    @(posedge aclk);
    check(32'(ia), 32'h0000_0001);
    dma <= 3'h1;
    @(posedge aclk);
    dma <= 3'h0;
    @(posedge aclk);
    check(32'(ia), 32'h0000_0000);
    ev_a <= 3'h1;
    dma <= 3'h1;
    @(posedge aclk);
    ev_a <= 3'h0;
    dma <= 3'h0;
    @(posedge aclk);
    check(32'(ia), 32'h0000_0001);
    cnt_up <= 3'h2;
    rd(5'h14);
    check(got, 32'h0000_0040);
    rd(5'h0c);
    check(got, 32'h0000_00c3);
    wr(5'h00, 8'h00);
    check(32'({ia[0], ib[0]}), 32'h0000_0000);
    standby <= 1'b1;
    @(posedge aclk);
    standby <= 1'b0;
    rd(5'h10);
    check(got, 32'h0000_00c0);
    check(32'({ia, ib, io, iu, ic, id}), 32'h0000_0000);
    rd(5'h04);
    check(got, 32'h0000_0040);
    end_sim();
  end
endmodule // timer_status_irq_flags_tb
